/* File: inc/tsc_pkg.sv */
// shared constants, register map and carrier types of the track segment correlator
package tsc_pkg;

  // input geometry
  localparam int NUM_INNER = 4;
  localparam int NUM_OUTER = 12;
  localparam int NUM_SF    = 16;

  // geographic position offsets per input, in local position units
  localparam logic [8:0] INNER_POS_BASE = 9'h080;
  localparam logic [8:0] POS_STEP       = 9'h020;

  // register byte offsets
  localparam logic [7:0] REG_CONTROL  = 8'h00;
  localparam logic [7:0] REG_SORT     = 8'h04;
  localparam logic [7:0] REG_MASK     = 8'h08;
  localparam logic [7:0] REG_ANGLE    = 8'h0c;
  localparam logic [7:0] REG_WINDOW   = 8'h10;
  localparam logic [7:0] REG_LUT_ADDR = 8'h14;
  localparam logic [7:0] REG_LUT_DATA = 8'h18;
  localparam logic [7:0] REG_STATUS   = 8'h1c;

  // control register bits
  localparam int CTL_REUSE_EN   = 0;
  localparam int CTL_XVIEW_EN   = 1;
  localparam int CTL_XVIEW_HQ   = 2;
  localparam int CTL_LTS_EN     = 3;
  localparam int CTL_SOFT_CLEAR = 4;
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0001;

  // mask field bit positions: {layer, low, high}
  localparam int MSK_HIGH  = 0;
  localparam int MSK_LOW   = 1;
  localparam int MSK_LAYER = 2;
  localparam int MSK_SECOND_LSB  = 4;
  localparam int MSK_PREVIEW_LSB = 8;

  // angle register fields
  localparam int ANG_GEO_LSB   = 0;
  localparam int ANG_DRIFT_LSB = 8;
  localparam int ANG_SHIFT_LSB = 16;

  // window register fields and reset value
  localparam int WIN_BEND_LSB = 16;
  localparam logic [31:0] WINDOW_RESET = 32'h03ff_00ff;

  // lookup table address register: table select bit
  localparam int LUT_SEL_BIT = 16;

  // output quality codes
  localparam logic [2:0] QUAL_BOTH_HIGH = 3'h6;
  localparam logic [2:0] QUAL_MIXED     = 3'h5;
  localparam logic [2:0] QUAL_BOTH_LOW  = 3'h4;
  localparam logic [2:0] QUAL_NULL      = 3'h7;

  // one segment finder link: strobe, quality, multiplexed angle or position
  typedef struct packed {
    logic       strobe;
    logic       quality;
    logic [5:0] data;
  } tsc_sf_type;

  // converted candidate
  typedef struct packed {
    logic       valid;
    logic       quality;
    logic [5:0] k;
    logic [8:0] pos;
  } tsc_cand_type;

  // selected track before coordinate conversion
  typedef struct packed {
    logic       valid;
    logic       correlated;
    logic       used_inner;
    logic       used_outer;
    logic [2:0] code;
    logic [8:0] pos;
    logic [9:0] k;
  } tsc_sel_type;

  // preview word with its valid
  typedef struct packed {
    logic       valid;
    logic       quality;
    logic       second;
    logic       outer;
    logic       correlated;
    logic [4:0] magnitude;
  } tsc_preview_type;

  // output track
  typedef struct packed {
    logic [2:0]  quality;
    logic [11:0] radial;
    logic [9:0]  bend;
  } tsc_track_type;

endpackage

/* File: hw/tsc_track_correlator.sv */
// track segment correlator: input latch, sorters, correlation, selection, lookup and output mixer
//
// Chosen here: the APB interface to the registers and the address map.
`timescale 1ns/100ps

//Contract
// (RQ1) Two track flows one cycle apart; second uses candidates the first left unused.
// (RQ2) Each track has its own preview bus carrying one candidate angle.
// (RQ3) Preview word: five bit magnitude, quality, second, outer, correlated bits.
// (RQ4) Input register holds sixteen 8-bit entries: four inner, twelve outer.
// (RQ5) Each finder sends angle then position on six lines, plus quality and strobe.
// (RQ6) Angle made local by subtracting geographic load and drift offset.
// (RQ7) Position offset geographically per input plus programmable superlayer shift.
// (RQ8) First path has inner and outer sorters picking smallest angle by default.
// (RQ9) Sorters programmable for largest angle and/or high-quality preference.
// (RQ10) Second path sorters have their own independent settings.
// (RQ11) Correlated angle and position computed; flag only inside acceptance window.
// (RQ12) Forward correlated track, else uncorrelated by preference, else lone candidate.
// (RQ13) Track selectors use high, low, layer masks; preview uses low and layer only.
// (RQ14) Cross-view coincidence certifies uncorrelated low triggers, optionally high ones.
// (RQ15) Quality code: 6,5,4 correlated; 3,2,1,0 uncorrelated; 7 null.
// (RQ16) Unused candidate of failed correlation goes to second path unless disabled.
// (RQ17) First track wins the bus over an older second track; overlap flagged.
// (RQ18) Lookup tables: 9-bit position to 12-bit radial, 10-bit angle to 10-bit.
// (RQ19) Bending angle is radial angle minus track angle.
// (RQ20) Filter drops uncorrelated low triggers and bending angles outside tolerance.
// (RQ21) Output carries bend 10, radial 12, quality 3; two tracks on consecutive cycles.
// (RQ22) First track out five cycles after input, second track six.
// (RQ23) Upstream high quality means four aligned hits, low means three of four.
// (RQ24) Synchronous clear empties the pipeline so outputs show null tracks.
module tsc_track_correlator
  import tsc_pkg::*;
(
  // clock and reset
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  // apb slave
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [7:0]                   paddr,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  // segment finder links and orthogonal view
  input  wire tsc_sf_type [NUM_SF-1:0]      sf_in,
  input  wire logic                         theta_coincidence,
  // preview buses
  output tsc_preview_type                   preview_first,
  output tsc_preview_type                   preview_second,
  // track output bus
  output tsc_track_type                     track_out,
  output logic                              track_valid,
  output logic                              track_second,
  output logic                              track_overlap
);

  // configuration registers
  logic [31:0] control;
  logic [7:0]  sort_cfg;
  logic [9:0]  mask_cfg;
  logic [31:0] angle_cfg;
  logic [31:0] window_cfg;
  logic [9:0]  lut_addr;
  logic        lut_sel;
  logic        overlap_seen;
  logic        sync_clear;
  logic [11:0] pos_lut [512];
  logic [9:0]  k_lut   [1024];

  // pipeline state
  tsc_sf_type   [NUM_SF-1:0] in_reg;
  tsc_cand_type [NUM_SF-1:0] cand;
  tsc_cand_type [NUM_SF-1:0] cand_s3;
  tsc_cand_type [NUM_SF-1:0] cand_s4;
  wire tsc_cand_type [NUM_SF-1:0] next_cand;
  tsc_cand_type ci1;
  tsc_cand_type co1;
  logic [3:0]   fi_idx;
  logic [3:0]   fo_idx;
  logic         coinc_s2;
  logic         coinc_s3;
  logic         coinc_s4;
  tsc_sel_type  sel1;
  tsc_sel_type  sel2;

  // combinational results
  logic [4:0]   pick_fi;
  logic [4:0]   pick_fo;
  logic [4:0]   pick_si;
  logic [4:0]   pick_so;
  tsc_cand_type ci2;
  tsc_cand_type co2;
  tsc_sel_type  next_sel1;
  tsc_cand_type [NUM_SF-1:0] next_avail;
  tsc_sel_type  mix;
  logic         mix_second;
  logic         mix_overlap;
  logic [11:0]  radial;
  logic [11:0]  bend_full;
  logic         keep;

  // apb decode
  logic        wr_en;
  logic        access;
  logic        mapped;

  // magnitude of a two's complement angle; -32 wraps, accepted limitation
  function automatic logic [4:0] magnitude(input logic [5:0] k);
    logic [5:0] a;
    a = k[5] ? 6'(-k) : k;
    return a[4:0];
  endfunction

  function automatic logic [9:0] abs10(input logic [9:0] v);
    return v[9] ? 10'(-v) : v;
  endfunction

  // returns {found, index}; ties keep the lower index
  function automatic logic [4:0] sort_pick(input tsc_cand_type [NUM_OUTER-1:0] c,
                                           input logic largest, input logic prefer_hq);
    logic       found;
    logic [3:0] best;
    logic       better;
    found = 1'b0;
    best  = 4'h0;
    for (int i = 0; i < NUM_OUTER; i++)
    begin
      if (!found)
        better = 1'b1;
      else if (prefer_hq && (c[i].quality != c[best].quality))
        better = c[i].quality; // [RQ9]
      else if (largest)
        better = magnitude(c[i].k) > magnitude(c[best].k); // [RQ9]
      else
        better = magnitude(c[i].k) < magnitude(c[best].k); // [RQ8]
      if (c[i].valid && better)
      begin
        found = 1'b1;
        best  = 4'(i);
      end
    end
    return {found, best};
  endfunction

  function automatic tsc_cand_type [NUM_OUTER-1:0] inner_of(input tsc_cand_type [NUM_SF-1:0] a);
    tsc_cand_type [NUM_OUTER-1:0] r;
    r = '0;
    r[NUM_INNER-1:0] = a[NUM_INNER-1:0];
    return r;
  endfunction

  // layer choice from masks when both layers hold a candidate
  function automatic logic take_outer(input tsc_cand_type ci, input tsc_cand_type co,
                                      input logic use_hq, input logic low_layer, input logic layer);
    if (!ci.valid)
      return 1'b1;
    else if (!co.valid)
      return 1'b0;
    else if (use_hq && (ci.quality != co.quality))
      return co.quality;
    else if (!ci.quality && !co.quality)
      return low_layer;
    else
      return layer;
  endfunction

  // correlation, priority selection and quality coding of one track
  function automatic tsc_sel_type pick_track(input tsc_cand_type ci, input tsc_cand_type co,
                                             input logic [2:0] msk, input logic [7:0] win,
                                             input logic coinc);
    tsc_sel_type  s;
    tsc_cand_type c;
    logic [9:0]   kc;
    logic [9:0]   ks;
    logic [9:0]   xsum;
    logic         outer;
    logic         cert;
    s      = '0;
    s.code = QUAL_NULL; // [RQ15]
    kc     = {1'b0, ci.pos} - {1'b0, co.pos};                      // [RQ11]
    ks     = {{4{ci.k[5]}}, ci.k} + {{4{co.k[5]}}, co.k};
    xsum   = {1'b0, ci.pos} + {1'b0, co.pos};
    outer  = take_outer(ci, co, msk[MSK_HIGH], msk[MSK_LOW], msk[MSK_LAYER]); // [RQ13]
    c      = outer ? co : ci;
    cert   = !control[CTL_XVIEW_EN] || coinc || (c.quality && !control[CTL_XVIEW_HQ]); // [RQ14]
    if (ci.valid && co.valid && (abs10(10'(kc - ks)) <= {2'h0, win})) // [RQ11]
    begin
      s.valid      = 1'b1;
      s.correlated = 1'b1;
      s.used_inner = 1'b1;
      s.used_outer = 1'b1;
      s.pos        = xsum[9:1];
      s.k          = kc;
      if (ci.quality && co.quality)
        s.code = QUAL_BOTH_HIGH; // [RQ15]
      else if (ci.quality || co.quality)
        s.code = QUAL_MIXED;
      else
        s.code = QUAL_BOTH_LOW;
    end
    else if (c.valid && cert) // [RQ12]
    begin
      s.valid      = 1'b1;
      s.code       = {1'b0, c.quality, outer}; // [RQ15]
      s.pos        = c.pos;
      s.k          = {{4{c.k[5]}}, c.k};
      // the other candidate stays free for the second track unless reuse is off
      s.used_inner = !outer || (ci.valid && !control[CTL_REUSE_EN]); // [RQ16]
      s.used_outer = outer || (co.valid && !control[CTL_REUSE_EN]);
    end
    return s;
  endfunction

  // preview picks inner or outer with the low and layer masks only
  function automatic tsc_preview_type preview_of(input tsc_cand_type ci, input tsc_cand_type co,
                                                 input logic second);
    tsc_preview_type p;
    tsc_cand_type    c;
    logic            outer;
    outer = take_outer(ci, co, 1'b0, mask_cfg[MSK_PREVIEW_LSB], mask_cfg[MSK_PREVIEW_LSB+1]); // [RQ13]
    c     = outer ? co : ci;
    p.valid      = c.valid;
    p.quality    = c.quality;   // [RQ3]
    p.second     = second;
    p.outer      = outer;
    p.correlated = ci.valid && co.valid;
    p.magnitude  = magnitude(c.k);
    return p;
  endfunction

  // per input conversion of angle and position
  for (genvar g = 0; g < NUM_SF; g++)
  begin : g_conv
    localparam logic [8:0] GEO = (g < NUM_INNER) ? 9'(INNER_POS_BASE + g * POS_STEP)
                                                 : 9'((g - NUM_INNER) * POS_STEP);
    localparam logic       IS_OUTER = (g >= NUM_INNER);
    assign next_cand[g].valid   = in_reg[g].strobe;
    assign next_cand[g].quality = in_reg[g].quality;
    assign next_cand[g].k       = in_reg[g].data - angle_cfg[ANG_GEO_LSB +: 6]
                                  - angle_cfg[ANG_DRIFT_LSB +: 6];          // [RQ6]
    assign next_cand[g].pos     = {3'h0, sf_in[g].data} + GEO
                                  + (IS_OUTER ? {{3{angle_cfg[ANG_SHIFT_LSB+5]}},
                                                 angle_cfg[ANG_SHIFT_LSB +: 6]} : 9'h000); // [RQ7]
  end

  // input register and converted candidates; angle in strobe cycle, position next
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      in_reg   <= '0;
      cand     <= '0;
      coinc_s2 <= 1'b0;
    end
    else if (sync_clear)
    begin
      in_reg   <= '0; // [RQ24]
      cand     <= '0;
      coinc_s2 <= 1'b0;
    end
    else
    begin
      in_reg   <= sf_in;      // [RQ4] [RQ5]
      cand     <= next_cand;
      coinc_s2 <= theta_coincidence;
    end

  // sorting for both paths, each with its own settings
  always_comb
  begin
    pick_fi = sort_pick(inner_of(cand), sort_cfg[0], sort_cfg[1]);                  // [RQ8]
    pick_fo = sort_pick(cand[NUM_SF-1:NUM_INNER], sort_cfg[2], sort_cfg[3]);
    pick_si = sort_pick(inner_of(cand_s4), sort_cfg[4], sort_cfg[5]);               // [RQ10]
    pick_so = sort_pick(cand_s4[NUM_SF-1:NUM_INNER], sort_cfg[6], sort_cfg[7]);
    ci2     = pick_si[4] ? cand_s4[pick_si[3:0]] : '0;
    co2     = pick_so[4] ? cand_s4[5'(NUM_INNER) + {1'b0, pick_so[3:0]}] : '0;
  end

  // first track sort stage and first preview
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn || sync_clear)
    begin
      ci1           <= '0;
      co1           <= '0;
      fi_idx        <= 4'h0;
      fo_idx        <= 4'h0;
      cand_s3       <= '0;
      coinc_s3      <= 1'b0;
      preview_first <= '0;
    end
    else
    begin
      ci1           <= pick_fi[4] ? cand[pick_fi[3:0]] : '0;
      co1           <= pick_fo[4] ? cand[5'(NUM_INNER) + {1'b0, pick_fo[3:0]}] : '0;
      fi_idx        <= pick_fi[3:0];
      fo_idx        <= pick_fo[3:0];
      cand_s3       <= cand;
      coinc_s3      <= coinc_s2;
      preview_first <= preview_of(pick_fi[4] ? cand[pick_fi[3:0]] : '0,
                                  pick_fo[4] ? cand[5'(NUM_INNER) + {1'b0, pick_fo[3:0]}] : '0,
                                  1'b0); // [RQ2]
    end

  // first selection and removal of its candidates for the delayed path
  always_comb
  begin
    next_sel1  = pick_track(ci1, co1, mask_cfg[2:0], window_cfg[7:0], coinc_s3);
    next_avail = cand_s3;
    if (next_sel1.used_inner)
      next_avail[fi_idx].valid = 1'b0; // [RQ1]
    if (next_sel1.used_outer)
      next_avail[5'(NUM_INNER) + {1'b0, fo_idx}].valid = 1'b0;
  end

  // first selection stage and delayed second path
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn || sync_clear)
    begin
      sel1           <= '0;
      cand_s4        <= '0;
      coinc_s4       <= 1'b0;
      sel2           <= '0;
      preview_second <= '0;
    end
    else
    begin
      sel1           <= next_sel1;
      cand_s4        <= next_avail;   // [RQ1]
      coinc_s4       <= coinc_s3;
      sel2           <= pick_track(ci2, co2, mask_cfg[MSK_SECOND_LSB +: 3], window_cfg[7:0], coinc_s4);
      preview_second <= preview_of(ci2, co2, 1'b1); // [RQ2]
    end

  // mixer, lookup, bending angle and quality filter
  always_comb
  begin
    mix_overlap = sel1.valid && sel2.valid;                  // [RQ17]
    mix_second  = !sel1.valid && sel2.valid;
    mix         = sel1.valid ? sel1 : sel2;
    radial      = pos_lut[mix.pos];                          // [RQ18]
    bend_full   = radial - {2'h0, k_lut[mix.k]};             // [RQ19]
    keep        = mix.valid
                  && !(control[CTL_LTS_EN] && !mix.correlated && !mix.code[1])            // [RQ20]
                  && (abs10(bend_full[9:0]) <= window_cfg[WIN_BEND_LSB +: 10]);
  end

  // output bus: first five, second six edges after the strobe cycle
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn || sync_clear)
    begin
      track_out     <= '{quality: QUAL_NULL, radial: 12'h000, bend: 10'h000}; // [RQ24]
      track_valid   <= 1'b0;
      track_second  <= 1'b0;
      track_overlap <= 1'b0;
    end
    else
    begin
      track_out     <= keep ? '{quality: mix.code, radial: radial, bend: bend_full[9:0]}
                            : '{quality: QUAL_NULL, radial: 12'h000, bend: 10'h000}; // [RQ21] [RQ22]
      track_valid   <= keep;
      track_second  <= keep && mix_second;
      track_overlap <= mix_overlap; // [RQ17]
    end

  // apb decode; zero wait states
  assign access  = psel && penable;
  assign wr_en   = access && pwrite && mapped;
  assign mapped  = (paddr[1:0] == 2'h0) && (paddr <= REG_STATUS);
  assign pready  = 1'b1;
  assign pslverr = access && !mapped;

  // configuration writes; soft clear is a one-cycle pulse
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      control    <= CONTROL_RESET;
      sort_cfg   <= 8'h00;
      mask_cfg   <= 10'h000;
      angle_cfg  <= 32'h0000_0000;
      window_cfg <= WINDOW_RESET;
      sync_clear <= 1'b0;
    end
    else
    begin
      sync_clear <= wr_en && (paddr == REG_CONTROL) && pwdata[CTL_SOFT_CLEAR]; // [RQ24]
      if (wr_en && (paddr == REG_CONTROL))
        control    <= {28'h0, pwdata[3:0]};
      if (wr_en && (paddr == REG_SORT))
        sort_cfg   <= pwdata[7:0];                      // [RQ9] [RQ10]
      if (wr_en && (paddr == REG_MASK))
        mask_cfg   <= pwdata[9:0] & 10'h377;
      if (wr_en && (paddr == REG_ANGLE))
        angle_cfg  <= pwdata & 32'h003f_3f3f;
      if (wr_en && (paddr == REG_WINDOW))
        window_cfg <= pwdata & 32'h03ff_00ff;
    end

  // lookup table pointer, auto-increments on each data write
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      lut_addr <= 10'h000;
      lut_sel  <= 1'b0;
    end
    else if (wr_en && (paddr == REG_LUT_ADDR))
    begin
      lut_addr <= pwdata[9:0];
      lut_sel  <= pwdata[LUT_SEL_BIT];
    end
    else if (wr_en && (paddr == REG_LUT_DATA))
      lut_addr <= lut_addr + 10'h001;

  // table contents are not reset; software loads them before use
  always_ff @(posedge pclk)
    if (wr_en && (paddr == REG_LUT_DATA))
    begin
      if (lut_sel)
        k_lut[lut_addr] <= pwdata[9:0];        // [RQ18]
      else
        pos_lut[lut_addr[8:0]] <= pwdata[11:0];
    end

  // sticky overlap flag, write one to clear; a new overlap wins over the clear
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      overlap_seen <= 1'b0;
    else if (mix_overlap)
      overlap_seen <= 1'b1;
    else if (wr_en && (paddr == REG_STATUS) && pwdata[0])
      overlap_seen <= 1'b0;

  // read data registered in the setup phase so it stands through the access phase
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable)
    begin
      case (paddr)
        REG_CONTROL:  prdata <= control;
        REG_SORT:     prdata <= {24'h0, sort_cfg};
        REG_MASK:     prdata <= {22'h0, mask_cfg};
        REG_ANGLE:    prdata <= angle_cfg;
        REG_WINDOW:   prdata <= window_cfg;
        REG_LUT_ADDR: prdata <= {15'h0, lut_sel, 6'h0, lut_addr};
        REG_LUT_DATA: prdata <= lut_sel ? {22'h0, k_lut[lut_addr]} : {20'h0, pos_lut[lut_addr[8:0]]};
        REG_STATUS:   prdata <= {30'h0, track_valid, overlap_seen};
        default:      prdata <= 32'h0000_0000;
      endcase
    end

endmodule

/* File: sim/tsc_sf_model.sv */
// segment finder model: sixteen links sending angle then position
`timescale 1ns/100ps
module tsc_sf_model
  import tsc_pkg::*;
(
  // clock, reset and crossing request
  input  wire logic               pclk, presetn, fire,
  input  wire logic [NUM_SF-1:0]  mask, hq,
  // links into the correlator
  output tsc_sf_type [NUM_SF-1:0] sf_in
);
  logic pos_next;
  // angle of finder i is i; idle lines toggle so stale data never looks valid
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pos_next <= 1'b0;
      sf_in    <= '0;
    end
    else
    begin
      pos_next <= fire;
      for (int i = 0; i < NUM_SF; i++)
      begin
        sf_in[i].strobe  <= fire & mask[i];
        sf_in[i].quality <= fire ? hq[i] : ~sf_in[i].quality;
        sf_in[i].data    <= fire ? 6'(i) : pos_next ? 6'h00 : ~sf_in[i].data;
      end
    end
  end
endmodule

/* File: sim/tsc_track_correlator_asserts.sv */
// port assertions of the track correlator
`timescale 1ns/100ps
module tsc_chk
  import tsc_pkg::*;
(
  // clock, reset and apb
  input wire logic                    pclk, presetn, psel, penable, pready, pslverr,
  input wire logic [7:0]              paddr,
  // links and outputs
  input wire tsc_sf_type [NUM_SF-1:0] sf_in,
  input wire tsc_preview_type         preview_first, preview_second,
  input wire tsc_track_type           track_out,
  input wire logic                    track_valid, track_second, track_overlap
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic any_stb;
  logic bad_addr;
  // a crossing starts when any finder strobes
  always_comb
  begin
    any_stb = 1'b0;
    for (int i = 0; i < NUM_SF; i++)
      any_stb = any_stb | sf_in[i].strobe;
  end
  assign bad_addr = paddr > 8'h1c || paddr[1:0] != 2'h0;
  sequence s_first_out;
    track_valid && !track_second;
  endsequence
  sequence s_second_out;
    track_valid && track_second;
  endsequence
  a_err_unmapped: assert property (psel && penable && bad_addr |-> pslverr)
    else $error("no error on bad address");
  a_err_only_bad: assert property (pslverr |-> psel && penable && bad_addr)
    else $error("spurious error");
  a_null_idle: assert property (!track_valid |-> track_out == {QUAL_NULL, 22'h0})
    else $error("idle bus not null");
  a_live_code: assert property (track_valid |-> track_out.quality != QUAL_NULL)
    else $error("valid track with null code");
  a_first_latency: assert property (s_first_out |-> $past(any_stb, 5))
    else $error("first track latency");
  a_second_latency: assert property (s_second_out |-> $past(any_stb, 6))
    else $error("second track latency");
  a_preview_first: assert property (preview_first.valid |-> !preview_first.second && $past(any_stb, 3))
    else $error("first preview");
  a_preview_second: assert property (preview_second.valid |-> preview_second.second && $past(any_stb, 5))
    else $error("second preview");
  a_overlap_first: assert property (track_overlap |-> !track_second)
    else $error("overlap kept second");
endmodule
bind tsc_track_correlator tsc_chk i_chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr, .paddr, .sf_in,
  .preview_first, .preview_second, .track_out, .track_valid, .track_second, .track_overlap);

/* File: sim/tsc_track_correlator_test.sv */
// self-checking bench of the track correlator
`timescale 1ns/100ps
module tsc_track_correlator_test
  import tsc_pkg::*;
;
  // bench inputs
  logic                    pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic                    fire = 1'b0, theta_coincidence = 1'b0;
  logic [7:0]              paddr = 8'h00;
  logic [31:0]             pwdata = 32'h0;
  logic [NUM_SF-1:0]       mask = '0, hq = '0;
  // design outputs
  logic [31:0]             prdata;
  logic                    pready, pslverr, track_valid, track_second, track_overlap;
  tsc_sf_type [NUM_SF-1:0] sf_in;
  tsc_preview_type         preview_first, preview_second;
  tsc_track_type           track_out, first_seen;
  int                      bad_count = 0, n_compared = 0;
  tsc_sf_model i_sf (.pclk, .presetn, .fire, .mask, .hq, .sf_in);
  tsc_track_correlator i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .sf_in, .theta_coincidence, .preview_first, .preview_second, .track_out, .track_valid,
    .track_second, .track_overlap);
  always #2 pclk = ~pclk;
  task automatic check(input logic [63:0] s, x);
    n_compared++;
    if (s !== x)
    begin
      bad_count++;
      $display("BAD %0t: seen %h expected %h", $time, s, x);
    end
  endtask
  // one apb transfer; the slave's pready is waited for, not assumed
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic ex);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    check({q, 32'(e)}, {x, 32'(ex)});
  endtask
  // one crossing: preview seen in c3, first track in c5, second in c6
  task automatic frame(input logic [15:0] m, h, input logic [9:0] pv, input logic [2:0] q1, q2);
    @(posedge pclk);
    mask <= m;
    hq   <= h;
    fire <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
    repeat (3) @(posedge pclk);
    #1 check(64'(preview_first), 64'(pv));
    repeat (2) @(posedge pclk);
    #1 first_seen = track_out;
    check(64'({track_valid, track_second, track_out.quality}), 64'({q1 != QUAL_NULL, 1'b0, q1}));
    @(posedge pclk);
    #1 check(64'({track_valid, track_valid & track_second, track_out.quality}),
             64'({q2 != QUAL_NULL, q2 != QUAL_NULL, q2}));
  endtask
  task automatic wrap_up();
    $display("compared %0d, bad %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    #1 check(64'({track_out, preview_first, preview_second}), 64'({QUAL_NULL, 42'h0}));
    rd(REG_CONTROL, CONTROL_RESET, 1'b0);
    rd(REG_WINDOW, WINDOW_RESET, 1'b0);
    rd(REG_STATUS, 32'h0, 1'b0);
    rd(8'h20, 32'h0, 1'b1);
    rd(8'h06, 32'h0, 1'b1);
    // fill both tables; auto increment on write
    wr(REG_LUT_ADDR, 32'h0);
    for (int i = 0; i < 512; i++)
      wr(REG_LUT_DATA, i == 64 ? 32'h123 : 32'h0);
    wr(REG_LUT_ADDR, 32'h0001_0000);
    for (int i = 0; i < 1024; i++)
      wr(REG_LUT_DATA, i == 128 ? 32'h0a1 : 32'h0);
    wr(REG_LUT_ADDR, 32'h40);
    rd(REG_LUT_DATA, 32'h123, 1'b0);
    frame(16'h0031, 16'h0031, 10'h320, 3'h6, 3'h3);
    check(64'(first_seen), 64'({3'h6, 12'h123, 10'h082}));
    frame(16'h0031, 16'h0000, 10'h220, 3'h4, 3'h1);
    frame(16'h0011, 16'h0001, 10'h320, 3'h5, 3'h7);
    frame(16'h0001, 16'h0000, 10'h200, 3'h0, 3'h7);
    frame(16'h0001, 16'h0001, 10'h300, 3'h2, 3'h7);
    frame(16'h0010, 16'h0000, 10'h244, 3'h1, 3'h7);
    wr(REG_SORT, 32'h4);
    wr(REG_MASK, 32'h200);
    rd(REG_MASK, 32'h200, 1'b0);
    frame(16'h0031, 16'h0031, 10'h365, 3'h6, 3'h3);
    wr(REG_SORT, 32'h8);
    frame(16'h0031, 16'h0021, 10'h365, 3'h6, 3'h1);
    wr(REG_SORT, 32'h0);
    wr(REG_MASK, 32'h0);
    wr(REG_WINDOW, 32'h03ff_0000);
    frame(16'h0011, 16'h0011, 10'h320, 3'h2, 3'h3);
    wr(REG_MASK, 32'h4);
    frame(16'h0011, 16'h0011, 10'h320, 3'h3, 3'h2);
    wr(REG_CONTROL, 32'h0);
    frame(16'h0011, 16'h0011, 10'h320, 3'h3, 3'h7);
    wr(REG_CONTROL, 32'h2);
    frame(16'h0001, 16'h0001, 10'h300, 3'h2, 3'h7);
    wr(REG_CONTROL, 32'h6);
    frame(16'h0001, 16'h0001, 10'h300, 3'h7, 3'h7);
    frame(16'h0001, 16'h0000, 10'h200, 3'h7, 3'h7);
    @(posedge pclk);
    theta_coincidence <= 1'b1;
    frame(16'h0001, 16'h0000, 10'h200, 3'h0, 3'h7);
    wr(REG_CONTROL, 32'h8);
    frame(16'h0001, 16'h0000, 10'h200, 3'h7, 3'h7);
    wr(REG_WINDOW, 32'h0081_00ff);
    frame(16'h0011, 16'h0011, 10'h320, 3'h7, 3'h7);
    wr(REG_WINDOW, 32'h0082_00ff);
    frame(16'h0011, 16'h0011, 10'h320, 3'h6, 3'h7);
    wr(REG_CONTROL, 32'h18);
    rd(REG_CONTROL, 32'h8, 1'b0);
    wrap_up();
  end
  // hang guard; the run needs about 4800 cycles
  initial
  begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    wrap_up();
  end
endmodule
